// ==== rtl/ptp_defs.svh ====
// register offsets, field positions, reset values and timing for the block
`ifndef PTP_DEFS_SVH
`define PTP_DEFS_SVH
`define PTP_ADDR_HT_LOW 8'h8a
`define PTP_ADDR_HT_UPPER 8'h8b
`define PTP_ADDR_PROX_PERSISTENCE 8'h8c
`define PTP_ADDR_GENERAL_CONFIG_ZERO 8'h8d
`define PTP_ADDR_PROX_GAIN_PULSE_CONFIG 8'h8e
`define PTP_RST_HT_LOW 8'h00
`define PTP_RST_HT_UPPER 8'h00
`define PTP_RST_PROX_PERSISTENCE 8'h00
`define PTP_RST_GENERAL_CONFIG_ZERO 8'h40
`define PTP_RST_PROX_GAIN_PULSE_CONFIG 8'h8f
`define PTP_UPPER_MSB 5
`define PTP_PROX_PERSISTENCE_MSB 3
`define PTP_WLONG_BIT 3
`define PTP_GAIN_MSB 7
`define PTP_GAIN_LSB 6
`define PTP_PULSE_MSB 5
`define PTP_WLONG_FACTOR 4'hc
`define PTP_APC_RES_MSB 9
`define PTP_APC_RES_LSB 2
`endif

// ==== rtl/ptp_pkg.sv ====
// types shared by the threshold and persistence block
package ptp_pkg;
	typedef enum logic [2:0] {
		PTP_IDLE = 3'b001,
		PTP_FIRE = 3'b010,
		PTP_WAIT = 3'b100
	} ptp_pulse_state_e;
	typedef logic [13:0] ptp_thresh_t;
endpackage

// ==== rtl/ptp_pulse_ctl.sv ====
// emitter pulse sequencer for one proximity cycle
`timescale 1ns/1ps
`include "ptp_defs.svh"
module ptp_pulse_ctl
	import ptp_pkg::*;
#(
	parameter int CNT_W = 7
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic cycle_start,
	input wire logic pulse_done,
	input wire logic near_sat,
	input wire logic apc_off,
	input wire logic [CNT_W-1:0] pulse_limit,
	output logic pulse_fire_ff,
	output logic busy_ff,
	output logic cycle_done_ff,
	output logic [CNT_W-1:0] pulses_sent_ff
);
	ptp_pulse_state_e state_ff;
	ptp_pulse_state_e nxt_state;
	logic [CNT_W-1:0] nxt_sent;
	logic stop;

	assign nxt_sent = pulses_sent_ff + {{(CNT_W-1){1'b0}}, 1'b1};
	// stop at limit, or early on near saturation only under auto control
	assign stop = (nxt_sent >= pulse_limit) || (!apc_off && near_sat);

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			PTP_IDLE: begin
				if (cycle_start) begin
					nxt_state = PTP_FIRE;
				end
			end
			PTP_FIRE: begin
				nxt_state = PTP_WAIT;
			end
			PTP_WAIT: begin
				if (pulse_done) begin
					nxt_state = stop ? PTP_IDLE : PTP_FIRE;
				end
			end
			default: begin
				nxt_state = PTP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_ff <= PTP_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			pulses_sent_ff <= '0;
		end else if (state_ff == PTP_IDLE && cycle_start) begin
			pulses_sent_ff <= '0;
		end else if (state_ff == PTP_WAIT && pulse_done) begin
			pulses_sent_ff <= nxt_sent;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			pulse_fire_ff <= 1'b0;
			busy_ff <= 1'b0;
			cycle_done_ff <= 1'b0;
		end else begin
			pulse_fire_ff <= (nxt_state == PTP_FIRE);
			busy_ff <= (nxt_state != PTP_IDLE);
			cycle_done_ff <= (state_ff == PTP_WAIT) && pulse_done && stop;
		end
	end
endmodule

// ==== rtl/ptp_top.sv ====
// proximity threshold, persistence and pulse configuration block
// Overview of operation
// - high threshold is upper six bits above the low byte, fourteen bits.
// - high breach when result exceeds high threshold and persistence met.
// - low byte held in shadow, both parts loaded on upper write.
// - auto pulse off: 10-bit result, upper 8 bits vs low byte.
// - persistence 0 every cycle, 1 any outside, N after N consecutive.
// - count consecutive out-of-window results, interrupt when count equals setting.
// - a result inside the window clears the consecutive counter.
// - wait-long bit multiplies the proximity wait period by twelve.
// - gain field 7:6 selects 1x, 2x, 4x, 8x; resets to 4x.
// - pulse field 5:0 gives field plus one pulses; resets to 16 pulses.
// - auto pulse control adds pulses until limit or near saturation.
// - auto pulse control off sends exactly the programmed pulse count.
// - low breach when result below low threshold and persistence met.
// - above-high flag sets with interrupt on high side, clears with it.
// - wait period and its multiplier apply only with wait enabled.
`timescale 1ns/1ps
`include "ptp_defs.svh"
module ptp_top
	import ptp_pkg::*;
#(
	parameter int RES_W = 14
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata_ff,
	input wire logic [RES_W-1:0] prox_result,
	input wire logic result_valid,
	input wire logic [RES_W-1:0] low_thresh,
	input wire logic auto_pulse_control_off,
	input wire logic wait_enable,
	input wire logic [7:0] prox_wait_time,
	input wire logic irq_clear,
	input wire logic cycle_start,
	input wire logic pulse_done,
	input wire logic near_sat,
	output logic prox_irq_flag_ff,
	output logic above_high_flag_ff,
	output logic below_low_flag_ff,
	output logic [RES_W-1:0] high_thresh_ff,
	output logic [3:0] rx_gain_mult_ff,
	output logic [11:0] wait_units_ff,
	output logic [6:0] pulse_limit_ff,
	output logic pulse_fire_ff,
	output logic pulse_busy_ff,
	output logic cycle_done_ff,
	output logic [6:0] pulses_sent_ff
);
	logic [7:0] ht_shadow_ff;
	logic [7:0] ht_upper_ff;
	logic [7:0] prox_persistence_ff;
	logic [7:0] general_config_zero_ff;
	logic [7:0] prox_gain_pulse_config_ff;
	logic [RES_W-1:0] snap_res_ff;
	logic [RES_W-1:0] snap_hi_ff;
	logic [RES_W-1:0] snap_lo_ff;
	logic snap_apc_off_ff;
	logic eval_ff;
	logic [3:0] prox_persistence_cnt_ff;
	logic [3:0] nxt_prox_persistence_cnt;
	logic [7:0] cmp_res8;
	logic is_high;
	logic is_low;
	logic outside;
	logic fire;
	logic wr_hit_low;
	logic wr_hit_upper;
	logic [3:0] prox_persistence_set;

	assign wr_hit_low = reg_wr && (reg_addr == `PTP_ADDR_HT_LOW);
	assign wr_hit_upper = reg_wr && (reg_addr == `PTP_ADDR_HT_UPPER);
	assign prox_persistence_set = prox_persistence_ff[`PTP_PROX_PERSISTENCE_MSB:0];

	// low byte waits in shadow until the upper part arrives
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ht_shadow_ff <= `PTP_RST_HT_LOW;
		end else if (wr_hit_low) begin
			ht_shadow_ff <= reg_wdata;
		end
	end

	// both parts latched together on the upper write
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ht_upper_ff <= `PTP_RST_HT_UPPER;
			high_thresh_ff <= '0;
		end else if (wr_hit_upper) begin
			ht_upper_ff <= reg_wdata;
			high_thresh_ff <= {reg_wdata[`PTP_UPPER_MSB:0],
				ht_shadow_ff};
		end
	end

	// remaining configuration registers, reserved bits stored as written
	always_ff @(posedge clk) begin
		if (!rstn) begin
			prox_persistence_ff <= `PTP_RST_PROX_PERSISTENCE;
			general_config_zero_ff <= `PTP_RST_GENERAL_CONFIG_ZERO;
			prox_gain_pulse_config_ff <= `PTP_RST_PROX_GAIN_PULSE_CONFIG;
		end else if (reg_wr) begin
			case (reg_addr)
				`PTP_ADDR_PROX_PERSISTENCE: begin
					prox_persistence_ff <= reg_wdata;
				end
				`PTP_ADDR_GENERAL_CONFIG_ZERO: begin
					general_config_zero_ff <= reg_wdata;
				end
				`PTP_ADDR_PROX_GAIN_PULSE_CONFIG: begin
					prox_gain_pulse_config_ff <= reg_wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// read port, unmapped addresses read zero
	always_ff @(posedge clk) begin
		if (!rstn) begin
			reg_rdata_ff <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`PTP_ADDR_HT_LOW: begin
					reg_rdata_ff <= ht_shadow_ff;
				end
				`PTP_ADDR_HT_UPPER: begin
					reg_rdata_ff <= ht_upper_ff;
				end
				`PTP_ADDR_PROX_PERSISTENCE: begin
					reg_rdata_ff <= prox_persistence_ff;
				end
				`PTP_ADDR_GENERAL_CONFIG_ZERO: begin
					reg_rdata_ff <= general_config_zero_ff;
				end
				`PTP_ADDR_PROX_GAIN_PULSE_CONFIG: begin
					reg_rdata_ff <= prox_gain_pulse_config_ff;
				end
				default: begin
					reg_rdata_ff <= 8'h00;
				end
			endcase
		end
	end

	// snapshot of result and thresholds at the start of compare
	always_ff @(posedge clk) begin
		if (!rstn) begin
			snap_res_ff <= '0;
			snap_hi_ff <= '0;
			snap_lo_ff <= '0;
			snap_apc_off_ff <= 1'b0;
			eval_ff <= 1'b0;
		end else begin
			eval_ff <= result_valid;
			if (result_valid) begin
				snap_res_ff <= prox_result;
				snap_hi_ff <= high_thresh_ff;
				snap_lo_ff <= low_thresh;
				snap_apc_off_ff <= auto_pulse_control_off;
			end
		end
	end

	assign cmp_res8 = snap_res_ff[`PTP_APC_RES_MSB:`PTP_APC_RES_LSB];

	// window compare, 8-bit on upper result bits without auto control
	always_comb begin
		if (snap_apc_off_ff) begin
			is_high = cmp_res8 > snap_hi_ff[7:0];
			is_low = cmp_res8 < snap_lo_ff[7:0];
		end else begin
			is_high = snap_res_ff > snap_hi_ff;
			is_low = snap_res_ff < snap_lo_ff;
		end
	end

	assign outside = is_high || is_low;
	// counter saturates at fifteen, cleared inside the window
	assign nxt_prox_persistence_cnt = !outside ? 4'h0 :
		(prox_persistence_cnt_ff == 4'hf) ? 4'hf : prox_persistence_cnt_ff + 4'h1;
	// setting one fires on every outside result
	assign fire = eval_ff && ((prox_persistence_set == 4'h0) ||
		(outside && prox_persistence_set == 4'h1) ||
		(outside && nxt_prox_persistence_cnt == prox_persistence_set));

	always_ff @(posedge clk) begin
		if (!rstn) begin
			prox_persistence_cnt_ff <= 4'h0;
		end else if (eval_ff) begin
			prox_persistence_cnt_ff <= nxt_prox_persistence_cnt;
		end
	end

	// sticky flags, a new event wins over a clear in the same cycle
	always_ff @(posedge clk) begin
		if (!rstn) begin
			prox_irq_flag_ff <= 1'b0;
			above_high_flag_ff <= 1'b0;
			below_low_flag_ff <= 1'b0;
		end else if (fire) begin
			prox_irq_flag_ff <= 1'b1;
			above_high_flag_ff <= above_high_flag_ff || is_high;
			below_low_flag_ff <= below_low_flag_ff || is_low;
		end else if (irq_clear) begin
			prox_irq_flag_ff <= 1'b0;
			above_high_flag_ff <= 1'b0;
			below_low_flag_ff <= 1'b0;
		end
	end

	// gain decode, wait scaling and pulse limit
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rx_gain_mult_ff <= 4'h4;
			wait_units_ff <= 12'h000;
			pulse_limit_ff <= 7'h10;
		end else begin
			rx_gain_mult_ff <= 4'h1 <<
				prox_gain_pulse_config_ff[`PTP_GAIN_MSB:`PTP_GAIN_LSB];
			if (!wait_enable) begin
				wait_units_ff <= 12'h000;
			end else if (general_config_zero_ff[`PTP_WLONG_BIT]) begin
				wait_units_ff <= 12'({4'h0, prox_wait_time} *
					{8'h00, `PTP_WLONG_FACTOR});
			end else begin
				wait_units_ff <= {4'h0, prox_wait_time};
			end
			pulse_limit_ff <= {1'b0, prox_gain_pulse_config_ff[`PTP_PULSE_MSB:0]} +
				7'h01;
		end
	end

	ptp_pulse_ctl #(
		.CNT_W(7)
	) u_pulse (
		.clk(clk),
		.rstn(rstn),
		.cycle_start(cycle_start),
		.pulse_done(pulse_done),
		.near_sat(near_sat),
		.apc_off(auto_pulse_control_off),
		.pulse_limit(pulse_limit_ff),
		.pulse_fire_ff(pulse_fire_ff),
		.busy_ff(pulse_busy_ff),
		.cycle_done_ff(cycle_done_ff),
		.pulses_sent_ff(pulses_sent_ff)
	);
endmodule

// ==== testbench/ptp_host.sv ====
// host model driving the register byte bus
`timescale 1ns/1ps
module ptp_host (
	input wire logic clk,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata_ff
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		#1;
		d = reg_rdata_ff;
	endtask
	// low byte first, upper bits next, reserved bits at default
	task automatic set_high(input logic [13:0] t);
		wr(8'h8a, t[7:0]);
		wr(8'h8b, {2'b00, t[13:8]});
	endtask
endmodule

// ==== testbench/ptp_top_properties.sv ====
// port checks for the threshold, persistence and pulse block
`timescale 1ns/1ps
module ptp_top_chk #(
	parameter int RES_W = 14
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic result_valid,
	input wire logic irq_clear,
	input wire logic wait_enable,
	input wire logic cycle_start,
	input wire logic auto_pulse_control_off,
	input wire logic prox_irq_flag_ff,
	input wire logic above_high_flag_ff,
	input wire logic below_low_flag_ff,
	input wire logic [RES_W-1:0] high_thresh_ff,
	input wire logic [3:0] rx_gain_mult_ff,
	input wire logic [11:0] wait_units_ff,
	input wire logic [6:0] pulse_limit_ff,
	input wire logic pulse_fire_ff,
	input wire logic pulse_busy_ff,
	input wire logic cycle_done_ff,
	input wire logic [6:0] pulses_sent_ff
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	a_thresh_join: assert property (
		reg_wr && reg_addr == 8'h8b |=>
		high_thresh_ff[13:8] == $past(reg_wdata[5:0]))
		else $error("upper threshold bits not loaded");
	a_thresh_hold: assert property (
		!(reg_wr && reg_addr == 8'h8b) |=> $stable(high_thresh_ff))
		else $error("threshold moved without upper write");
	a_gain_map: assert property (
		reg_wr && reg_addr == 8'h8e |-> ##2
		rx_gain_mult_ff == 4'h1 << $past(reg_wdata[7:6], 2))
		else $error("gain multiplier wrong");
	a_pulse_limit: assert property (
		reg_wr && reg_addr == 8'h8e |-> ##2
		pulse_limit_ff == 7'($past(reg_wdata[5:0], 2)) + 7'h01)
		else $error("pulse limit wrong");
	a_irq_cause: assert property (
		$rose(prox_irq_flag_ff) |-> $past(result_valid, 2))
		else $error("interrupt without a result");
	a_irq_sticky: assert property (
		prox_irq_flag_ff && !irq_clear |=> prox_irq_flag_ff)
		else $error("interrupt dropped without clear");
	a_high_with_irq: assert property (
		$rose(above_high_flag_ff) |-> prox_irq_flag_ff)
		else $error("high flag without interrupt");
	a_flags_follow: assert property (
		!prox_irq_flag_ff |-> !above_high_flag_ff && !below_low_flag_ff)
		else $error("breach flag outlives interrupt");
	a_wait_off: assert property (
		!wait_enable [*3] |-> wait_units_ff == 12'h000)
		else $error("wait applied while disabled");
	a_fire_start: assert property (
		cycle_start && !pulse_busy_ff |=> pulse_fire_ff)
		else $error("no pulse after start");
	a_exact_count: assert property (
		cycle_done_ff && auto_pulse_control_off |->
		pulses_sent_ff == pulse_limit_ff)
		else $error("pulse count differs from limit");
	c_high: cover property (prox_irq_flag_ff && above_high_flag_ff);
	c_low: cover property (below_low_flag_ff);
	c_done: cover property (cycle_done_ff);
endmodule
bind ptp_top ptp_top_chk #(.RES_W(RES_W)) chk_u (.clk(clk), .rstn(rstn),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.result_valid(result_valid), .irq_clear(irq_clear),
	.wait_enable(wait_enable), .cycle_start(cycle_start),
	.auto_pulse_control_off(auto_pulse_control_off),
	.prox_irq_flag_ff(prox_irq_flag_ff),
	.above_high_flag_ff(above_high_flag_ff),
	.below_low_flag_ff(below_low_flag_ff), .high_thresh_ff(high_thresh_ff),
	.rx_gain_mult_ff(rx_gain_mult_ff), .wait_units_ff(wait_units_ff),
	.pulse_limit_ff(pulse_limit_ff), .pulse_fire_ff(pulse_fire_ff),
	.pulse_busy_ff(pulse_busy_ff), .cycle_done_ff(cycle_done_ff),
	.pulses_sent_ff(pulses_sent_ff));

// ==== testbench/tb_top.sv ====
// self-checking bench for the threshold and pulse block
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	wire logic [7:0] ra, wd, rdat;
	wire logic wr, rd;
	logic [13:0] res = 14'h0000, lo = 14'h0000;
	logic rv = 1'b0, auto_pulse_control = 1'b0, wen = 1'b0, clr = 1'b0, st = 1'b0;
	logic pd = 1'b0, sat = 1'b0;
	logic [7:0] wt = 8'h00, d;
	logic irq, hi, low, fire, busy, done;
	logic [13:0] hth;
	logic [3:0] gain;
	logic [11:0] wu;
	logic [6:0] lim, sent;
	logic [7:0] ad[5] = '{8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'h90};
	logic [7:0] ex[5] = '{8'h00, 8'h00, 8'h40, 8'h8f, 8'h00};
	int miscompares = 0, n_tests = 0;
	always #50 clk = ~clk;
	always @(posedge clk) pd <= fire;
	ptp_host host_u (.clk(clk), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr),
		.reg_rd(rd), .reg_rdata_ff(rdat));
	ptp_top dut_u (.clk(clk), .rstn(rstn), .reg_addr(ra), .reg_wdata(wd),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata_ff(rdat), .prox_result(res),
		.result_valid(rv), .low_thresh(lo), .auto_pulse_control_off(auto_pulse_control),
		.wait_enable(wen), .prox_wait_time(wt), .irq_clear(clr),
		.cycle_start(st), .pulse_done(pd), .near_sat(sat),
		.prox_irq_flag_ff(irq), .above_high_flag_ff(hi),
		.below_low_flag_ff(low), .high_thresh_ff(hth),
		.rx_gain_mult_ff(gain), .wait_units_ff(wu), .pulse_limit_ff(lim),
		.pulse_fire_ff(fire), .pulse_busy_ff(busy), .cycle_done_ff(done),
		.pulses_sent_ff(sent));
	task chk(input string what, input logic [15:0] s, input logic [15:0] e);
		n_tests++;
		if (s !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, e, s);
		end
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task result(input logic [13:0] v);
		@(posedge clk);
		res <= v;
		rv <= 1'b1;
		@(posedge clk);
		rv <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task clear;
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
	endtask
	task pulses(input logic [6:0] e);
		int k;
		int f;
		k = 0;
		f = 0;
		@(posedge clk);
		st <= 1'b1;
		@(posedge clk);
		st <= 1'b0;
		while (done !== 1'b1 && k < 500) begin
			@(posedge clk);
			k++;
			if (fire === 1'b1) f++;
		end
		if (k >= 500) begin
			miscompares++;
			final_report;
		end
		else begin
			chk("pulses", sent, e);
			chk("fires", 16'(f), e);
			chk("busy", busy, 1'b0);
		end
	endtask
	initial begin
		#5000000;
		miscompares++;
		final_report;
	end
	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			host_u.rd(ad[i], d);
			chk("reset reg", d, ex[i]);
		end
		chk("gain", gain, 4'h4);
		chk("limit", lim, 7'h10);
		host_u.set_high(14'h2a34);
		@(posedge clk);
		chk("high thresh", hth, 14'h2a34);
		host_u.wr(8'h8a, 8'h00);
		repeat (2) @(posedge clk);
		chk("high thresh", hth, 14'h2a34);
		host_u.rd(8'h8a, d);
		chk("shadow", d, 8'h00);
		for (int g = 0; g < 4; g++) begin
			host_u.wr(8'h8e, {g[1:0], 6'h3f});
			repeat (3) @(posedge clk);
			chk("gain", gain, 4'h1 << g);
			chk("limit", lim, 7'h40);
		end
		wt <= 8'h05;
		wen <= 1'b1;
		host_u.wr(8'h8d, 8'h48);
		repeat (3) @(posedge clk);
		chk("wait", wu, 12'd60);
		host_u.wr(8'h8d, 8'h40);
		repeat (3) @(posedge clk);
		chk("wait", wu, 12'h005);
		wen <= 1'b0;
		repeat (3) @(posedge clk);
		chk("wait", wu, 12'h000);
		host_u.wr(8'h8c, 8'h02);
		lo <= 14'h0100;
		result(14'h3000);
		chk("irq", irq, 1'b0);
		result(14'h3000);
		chk("irq", {irq, hi}, 2'b11);
		clear;
		result(14'h0200);
		result(14'h3000);
		result(14'h0200);
		result(14'h3000);
		chk("irq", irq, 1'b0);
		result(14'h0010);
		chk("low", {irq, hi, low}, 3'b101);
		clear;
		host_u.wr(8'h8c, 8'h00);
		result(14'h0200);
		chk("irq", irq, 1'b1);
		clear;
		host_u.wr(8'h8c, 8'h01);
		auto_pulse_control <= 1'b1;
		lo <= 14'h0000;
		host_u.set_high(14'h3f10);
		result(14'h0044);
		chk("apc off", {irq, hi}, 2'b11);
		clear;
		result(14'h0044);
		chk("prox_persistence one", {irq, hi}, 2'b11);
		host_u.wr(8'h8e, 8'h82);
		sat <= 1'b1;
		pulses(7'h03);
		auto_pulse_control <= 1'b0;
		pulses(7'h01);
		sat <= 1'b0;
		pulses(7'h03);
		final_report;
	end
endmodule
